// *** design/ifeb_pkg.sv ***
// shared constants and carrier types of the interrupt flag and enable bank
package ifeb_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PRIMARY_CTRL_1 = 8'h00;
  localparam logic [7:0] OFF_PRIMARY_CTRL_2 = 8'h04;
  localparam logic [7:0] OFF_MULTI_FUNC_0 = 8'h08;
  localparam logic [7:0] OFF_MULTI_FUNC_1 = 8'h0c;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h10;
  localparam logic [7:0] OFF_EVENT_MASK = 8'h14;

  // ---------------------------------------------------------------
  // register decode selectors
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_CTRL_1 = 3'h0;
  localparam logic [2:0] SEL_CTRL_2 = 3'h1;
  localparam logic [2:0] SEL_MFI_0 = 3'h2;
  localparam logic [2:0] SEL_MFI_1 = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_MASK = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // ---------------------------------------------------------------
  // field layout: flags in the high nibble, enables in the low nibble
  // ---------------------------------------------------------------
  localparam int FLAG_LSB = 4;
  localparam int NIBBLE_W = 4;
  localparam int STD_PAIR_W = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] MULTI_FUNC_IRQ_CTRL_0_UNUSED = 2'h0;

  // primary vector index (bit position in the primary flag vector)
  localparam int PV_TIMEBASE0 = 7;
  localparam int PV_CONVERTER = 6;
  localparam int PV_GROUP2 = 5;
  localparam int PV_GROUP1 = 4;
  localparam int PV_ASYNC_SERIAL = 3;
  localparam int PV_SERIAL_MODULE = 2;
  localparam int PV_EXT_PIN1 = 1;
  localparam int PV_TIMEBASE1 = 0;

  // timer flag vector: [5:2] compact/periodic, [1:0] standard timer
  localparam int TF_W = 6;
  localparam int TF_STD_LSB = 0;
  localparam int TF_MF1_LSB = 2;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic timebase0;
    logic converter;
    logic async_serial;
    logic serial_module;
    logic ext_pin1;
    logic timebase1;
  } ifeb_src_evt_t;

  typedef struct packed {
    logic compact_a;
    logic compact_p;
    logic periodic_a;
    logic periodic_p;
    logic std_a;
    logic std_p;
  } ifeb_tmr_evt_t;

  typedef struct packed {
    logic valid;
    logic [2:0] id;
  } ifeb_vec_req_t;

endpackage

// *** design/ifeb_bank.sv ***
// interrupt request flag and enable bank with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
//
// Notes on behaviour
// - time base 0 flag at first register bit 7
// - converter flag at first register bit 6
// - group 2, group 1 flags at bits 5, 4
// - four enables at first register bits 3..0
// - async serial flag bit 7, enable bit 3
// - serial module flag bit 6, enable bit 2
// - external pin 1 flag bit 5, enable bit 1
// - time base 1 flag bit 4, enable bit 0
// - standard timer A, P flags at bits 5, 4
// - standard timer A, P enables at bits 1, 0
// - unused multi-function 0 bits read zero
// - compact and periodic timer flags bits 7..4
// - compact and periodic timer enables bits 3..0
// - flag, enable and global enable request vector
// - any grouped flag rising sets group flag
// - servicing clears group flag and global enable
module ifeb_bank #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // source events, one-cycle pulses
  input wire ifeb_pkg::ifeb_src_evt_t src_evt,
  input wire ifeb_pkg::ifeb_tmr_evt_t tmr_evt,
  // core side
  input wire logic global_irq_enable,
  input wire logic service_ack,
  input wire logic [2:0] service_id,
  output ifeb_pkg::ifeb_vec_req_t vec_req,
  output logic global_enable_clear,
  output logic irq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ifeb_bank: ADDR_W must lie in 5..32");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // address to register selector, shared by both bus paths
  function automatic logic [2:0] ifeb_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    logic hi_zero;
    lo = 8'(a); // widens a narrow bus with zeros, cuts a wide one on purpose
    hi_zero = (a >> 8) == '0;
    if (!hi_zero) begin
      return ifeb_pkg::SEL_NONE;
    end
    case (lo)
      ifeb_pkg::OFF_PRIMARY_CTRL_1: return ifeb_pkg::SEL_CTRL_1;
      ifeb_pkg::OFF_PRIMARY_CTRL_2: return ifeb_pkg::SEL_CTRL_2;
      ifeb_pkg::OFF_MULTI_FUNC_0: return ifeb_pkg::SEL_MFI_0;
      ifeb_pkg::OFF_MULTI_FUNC_1: return ifeb_pkg::SEL_MFI_1;
      ifeb_pkg::OFF_EVENT_STATUS: return ifeb_pkg::SEL_STATUS;
      ifeb_pkg::OFF_EVENT_MASK: return ifeb_pkg::SEL_MASK;
      default: return ifeb_pkg::SEL_NONE;
    endcase
  endfunction

  // highest set bit wins; bit 7 is the highest priority vector
  function automatic logic [3:0] ifeb_pick(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = {1'b1, i[2:0]};
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] pflag_r;
  logic [7:0] pflag_nxt;
  logic [7:0] pen_r;
  logic [ifeb_pkg::TF_W-1:0] tflag_r;
  logic [ifeb_pkg::TF_W-1:0] tflag_nxt;
  logic [ifeb_pkg::TF_W-1:0] ten_r;
  logic [7:0] evt_status_r;
  logic [7:0] evt_status_nxt;
  logic [7:0] evt_mask_r;

  logic aw_held_r;
  logic w_held_r;
  logic [2:0] wsel_r;
  logic [7:0] wbyte_r;
  logic wbyte_en_r;
  logic wr_fire;
  logic [2:0] rsel;
  logic rd_fire;
  logic [7:0] rbyte;
  logic [3:0] pick;

  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rsel = ifeb_decode(s_axi_araddr);

  // ---------------------------------------------------------------
  // write address and data capture
  // ---------------------------------------------------------------
  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      wsel_r <= ifeb_pkg::SEL_NONE;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) || wr_fire;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wsel_r <= ifeb_decode(s_axi_awaddr);
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wbyte_r <= ifeb_pkg::RESET_BYTE;
      wbyte_en_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) || wr_fire;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wbyte_en_r <= s_axi_wstrb[0]; // registers live in byte lane 0 only
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ifeb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel_r == ifeb_pkg::SEL_NONE) ? ifeb_pkg::RESP_SLVERR :
                     ifeb_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data mux; upper bits of the word read zero
  always_comb begin
    rbyte = ifeb_pkg::RESET_BYTE;
    case (rsel)
      ifeb_pkg::SEL_CTRL_1: begin
        rbyte = {pflag_r[7:4], pen_r[7:4]};
      end
      ifeb_pkg::SEL_CTRL_2: begin
        rbyte = {pflag_r[3:0], pen_r[3:0]};
      end
      ifeb_pkg::SEL_MFI_0: begin
        rbyte = {ifeb_pkg::MULTI_FUNC_IRQ_CTRL_0_UNUSED, tflag_r[1:0],
                 ifeb_pkg::MULTI_FUNC_IRQ_CTRL_0_UNUSED, ten_r[1:0]};
      end
      ifeb_pkg::SEL_MFI_1: begin
        rbyte = {tflag_r[5:2], ten_r[5:2]};
      end
      ifeb_pkg::SEL_STATUS: rbyte = evt_status_r;
      ifeb_pkg::SEL_MASK: rbyte = evt_mask_r;
      default: rbyte = ifeb_pkg::RESET_BYTE;
    endcase
  end

  // one read in flight; arready drops until the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ifeb_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rbyte};
        s_axi_rresp <= (rsel == ifeb_pkg::SEL_NONE) ? ifeb_pkg::RESP_SLVERR :
                       ifeb_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // flag next state
  // ---------------------------------------------------------------
  // order: software write, then service clear, then hardware set;
  // a set arriving with a clear in the same cycle is never lost
  always_comb begin
    logic [7:0] sub_rise;
    logic grp1_set;
    logic grp2_set;
    sub_rise = 8'h00;
    grp1_set = 1'b0;
    grp2_set = 1'b0;
    tflag_nxt = tflag_r;
    if (wr_fire && wbyte_en_r && wsel_r == ifeb_pkg::SEL_MFI_0) begin
      tflag_nxt[1:0] = wbyte_r[5:4];
    end
    if (wr_fire && wbyte_en_r && wsel_r == ifeb_pkg::SEL_MFI_1) begin
      tflag_nxt[5:2] = wbyte_r[7:4];
    end
    tflag_nxt = tflag_nxt | {tmr_evt.compact_a, tmr_evt.compact_p, tmr_evt.periodic_a,
                             tmr_evt.periodic_p, tmr_evt.std_a, tmr_evt.std_p};
    // group flag follows any grouped flag that rises, however it rose
    grp1_set = |(tflag_nxt[1:0] & ~tflag_r[1:0]);
    grp2_set = |(tflag_nxt[5:2] & ~tflag_r[5:2]);
    pflag_nxt = pflag_r;
    if (wr_fire && wbyte_en_r && wsel_r == ifeb_pkg::SEL_CTRL_1) begin
      pflag_nxt[7:4] = wbyte_r[7:4];
    end
    if (wr_fire && wbyte_en_r && wsel_r == ifeb_pkg::SEL_CTRL_2) begin
      pflag_nxt[3:0] = wbyte_r[7:4];
    end
    if (service_ack) begin
      pflag_nxt[service_id] = 1'b0;
    end
    sub_rise[ifeb_pkg::PV_TIMEBASE0] = src_evt.timebase0;
    sub_rise[ifeb_pkg::PV_CONVERTER] = src_evt.converter;
    sub_rise[ifeb_pkg::PV_GROUP2] = grp2_set;
    sub_rise[ifeb_pkg::PV_GROUP1] = grp1_set;
    sub_rise[ifeb_pkg::PV_ASYNC_SERIAL] = src_evt.async_serial;
    sub_rise[ifeb_pkg::PV_SERIAL_MODULE] = src_evt.serial_module;
    sub_rise[ifeb_pkg::PV_EXT_PIN1] = src_evt.ext_pin1;
    sub_rise[ifeb_pkg::PV_TIMEBASE1] = src_evt.timebase1;
    pflag_nxt = pflag_nxt | sub_rise;
    // sticky event status: read clears, a new event wins
    evt_status_nxt = evt_status_r;
    if (rd_fire && rsel == ifeb_pkg::SEL_STATUS) begin
      evt_status_nxt = 8'h00;
    end
    evt_status_nxt = evt_status_nxt | (pflag_nxt & ~pflag_r);
  end

  // ---------------------------------------------------------------
  // flag registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pflag_r <= ifeb_pkg::RESET_BYTE;
      tflag_r <= '0;
    end else begin
      pflag_r <= pflag_nxt;
      tflag_r <= tflag_nxt;
    end
  end

  // ---------------------------------------------------------------
  // enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pen_r <= ifeb_pkg::RESET_BYTE;
      ten_r <= '0;
    end else if (wr_fire && wbyte_en_r) begin
      case (wsel_r)
        ifeb_pkg::SEL_CTRL_1: pen_r[7:4] <= wbyte_r[3:0];
        ifeb_pkg::SEL_CTRL_2: pen_r[3:0] <= wbyte_r[3:0];
        ifeb_pkg::SEL_MFI_0: ten_r[1:0] <= wbyte_r[1:0];
        ifeb_pkg::SEL_MFI_1: ten_r[5:2] <= wbyte_r[3:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event status, mask and interrupt line
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_r <= ifeb_pkg::RESET_BYTE;
      evt_mask_r <= ifeb_pkg::RESET_BYTE;
      irq <= 1'b0;
    end else begin
      evt_status_r <= evt_status_nxt;
      if (wr_fire && wbyte_en_r && wsel_r == ifeb_pkg::SEL_MASK) begin
        evt_mask_r <= wbyte_r;
      end
      irq <= |(evt_status_r & evt_mask_r); // one cycle behind the status bits
    end
  end

  // ---------------------------------------------------------------
  // vector request and global enable clear
  // ---------------------------------------------------------------
  // flags stay set while disabled; only the request is withheld
  assign pick = ifeb_pick(pflag_r & pen_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_req <= '0;
      global_enable_clear <= 1'b0;
    end else begin
      vec_req.valid <= pick[3] && global_irq_enable && !service_ack;
      vec_req.id <= pick[2:0];
      global_enable_clear <= service_ack;
    end
  end

endmodule

// *** verification/ifeb_bank_checker.sv ***
// port-level checks of the interrupt flag and enable bank
`timescale 1ns/1ns
module ifeb_bank_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic global_irq_enable,
  input wire logic service_ack,
  input wire ifeb_pkg::ifeb_vec_req_t vec_req,
  input wire logic global_enable_clear
);
  // ----------------------------------------
  // bus handshake sequences
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_multi_func_irq_ctrl_0;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ifeb_pkg::OFF_MULTI_FUNC_0;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
  a_multi_func_irq_ctrl_0_unused: assert property (rd_take_multi_func_irq_ctrl_0 |=>
    s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("unused bits read nonzero");
  a_vec_needs_gie: assert property (vec_req.valid |-> $past(global_irq_enable))
    else $error("vector without global enable");
  a_gclr_after_ack: assert property (service_ack |=> global_enable_clear)
    else $error("global enable not cleared");
  a_gclr_cause: assert property (global_enable_clear |-> $past(service_ack))
    else $error("stray global enable clear");
  a_vec_quiet_ack: assert property (service_ack |-> ##[1:2] !vec_req.valid)
    else $error("vector not held off after service");
endmodule

// *** verification/ifeb_bank_tb.sv ***
// self-checking bench of the interrupt flag and enable bank
`timescale 1ns/1ns
module ifeb_bank_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack;
  logic awready, wready, bvalid, arready, rvalid, gclr, irq;
  logic [7:0] awaddr, araddr, s_p, s_t0, s_t1;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] sid;
  ifeb_pkg::ifeb_src_evt_t src;
  ifeb_pkg::ifeb_tmr_evt_t tmr;
  ifeb_pkg::ifeb_vec_req_t vec;
  logic [7:0] m_reg [0:5];
  int n_fail, n_checks, seed;

  ifeb_bank #(.ADDR_W(8)) i_ifeb_bank (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_evt(src), .tmr_evt(tmr), .global_irq_enable(gie), .service_ack(ack),
    .service_id(sid), .vec_req(vec), .global_enable_clear(gclr), .irq(irq)
  );

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_resp(string nm, logic [1:0] e, logic [1:0] g);
    chk_word(nm, {30'h0, e}, {30'h0, g});
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  // valid held until its own ready is sampled; bready held until bvalid seen
  // no local limit: only the watchdog ends a wait for the answer
  task automatic axi_wr(logic [7:0] a, logic [7:0] d, logic [3:0] st, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bvalid !== 1'b1) begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1) begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [7:0] pflg();
    return {m_reg[0][7:4], m_reg[1][7:4]};
  endfunction
  task automatic snap();
    s_p = pflg();
    s_t0 = m_reg[2];
    s_t1 = m_reg[3];
  endtask
  // timer flag rises feed the groups, primary rises feed the status
  task automatic m_prop();
    if ((m_reg[2][5:4] & ~s_t0[5:4]) != 2'h0)
      m_reg[0][4] = 1'b1;
    if ((m_reg[3][7:4] & ~s_t1[7:4]) != 4'h0)
      m_reg[0][5] = 1'b1;
    m_reg[4] = m_reg[4] | (pflg() & ~s_p);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [3:0] st, logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, st, r);
    chk_resp("bresp", er, r);
    snap();
    if (er == ifeb_pkg::RESP_OKAY && st[0] && a != ifeb_pkg::OFF_EVENT_STATUS)
      m_reg[a[4:2]] = (a == ifeb_pkg::OFF_MULTI_FUNC_0) ? (d & 8'h33) : d;
    m_prop();
  endtask
  task automatic rd(int i);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(8'(i * 4), d, r);
    chk_word("rdata", {24'h0, m_reg[i]}, d);
    chk_resp("rresp", ifeb_pkg::RESP_OKAY, r);
    if (i == 4)
      m_reg[4] = 8'h00;
  endtask
  // one-cycle event pulses, flags set at the following edge
  task automatic pulse(logic [5:0] s, logic [5:0] t);
    @(posedge aclk);
    src <= s;
    tmr <= t;
    @(posedge aclk);
    src <= '0;
    tmr <= '0;
    snap();
    m_reg[0][7:6] = m_reg[0][7:6] | s[5:4];
    m_reg[1][7:4] = m_reg[1][7:4] | s[3:0];
    m_reg[3][7:4] = m_reg[3][7:4] | t[5:2];
    m_reg[2][5:4] = m_reg[2][5:4] | t[1:0];
    m_prop();
  endtask
  // highest enabled pending flag wins; serviced flag drops
  task automatic vchk();
    logic [7:0] en;
    int id;
    repeat (3) @(posedge aclk);
    en = pflg() & {m_reg[0][3:0], m_reg[1][3:0]};
    id = 0;
    for (int b = 0; b < 8; b++)
      if (en[b])
        id = b;
    chk_bit("irq", |(m_reg[4] & m_reg[5]), irq);
    chk_bit("gclr", 1'b0, gclr);
    chk_bit("vec_valid", gie && en != 8'h0, vec.valid);
    if (gie && en != 8'h0) begin
      chk_word("vec_id", 32'(id), {29'h0, vec.id});
      ack <= 1'b1;
      sid <= 3'(id);
      @(posedge aclk);
      ack <= 1'b0;
      if (id > 3)
        m_reg[0][id] = 1'b0;
      else
        m_reg[1][id + 4] = 1'b0;
      // one edge after the ack: clear pulse seen, request withheld
      @(posedge aclk);
      chk_bit("gclr", 1'b1, gclr);
      chk_bit("vec_valid", 1'b0, vec.valid);
    end
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // hang guard, far beyond the expected run of about 1200 cycles
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    logic [31:0] d, j;
    logic [1:0] r;
    seed = 32'h53fd;
    n_fail = 0;
    n_checks = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, gie, ack} = 8'h00;
    {awaddr, araddr, wdata, wstrb, sid, src, tmr} = '0;
    for (int i = 0; i < 6; i++)
      m_reg[i] = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(i);
    axi_rd(8'h20, d, r);
    chk_word("rdata", 32'h0, d);
    chk_resp("rresp", ifeb_pkg::RESP_SLVERR, r);
    wr(8'h20, 8'hff, 4'h1, ifeb_pkg::RESP_SLVERR);
    wr(ifeb_pkg::OFF_MULTI_FUNC_0, 8'hff, 4'h1, ifeb_pkg::RESP_OKAY);
    rd(2);
    for (int k = 0; k < 40; k++) begin
      j = $random(seed);
      gie <= j[13];
      wr({3'h0, 3'(j[10:8] % 6), 2'h0}, j[7:0], {3'h0, j[12]}, ifeb_pkg::RESP_OKAY);
      pulse(6'(j >> 16) & 6'(j >> 22), 6'(j >> 26) & 6'(j >> 20));
      vchk();
      for (int i = 0; i < 6; i++)
        rd(i);
    end
    // reset in mid-run, with flags and enables set, must clear everything
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      m_reg[i] = 8'h00;
    for (int i = 0; i < 6; i++)
      rd(i);
    chk_bit("irq", 1'b0, irq);
    chk_bit("vec_valid", 1'b0, vec.valid);
    end_of_test();
  end
endmodule

bind ifeb_bank ifeb_bank_checker #(.ADDR_W(ADDR_W)) i_ifeb_bank_checker (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .global_irq_enable,
  .service_ack, .vec_req, .global_enable_clear
);
